//--- lilc_regs.svh
`ifndef LILC_REGS_SVH
`define LILC_REGS_SVH

// register index; byte address is four times the index
`define LILC_LIC_INDEX      12'h0101
`define LILC_LIC_ADDR       14'h0404
`define LILC_LIC_RESET      8'h00
`define LILC_FORCE_BIT      7
`define LILC_SRAIL_BIT      6
`define LILC_LB_HI          5
`define LILC_LB_LO          4
`define LILC_RSV_HI         3
`define LILC_RSV_LO         2
`define LILC_ALL_ONES       2'h3

`endif

//--- lilc_pkg.sv
package lilc_pkg;
	typedef enum logic [1:0] {
		LILC_LB_NORMAL  = 2'b00,
		LILC_LB_LOCAL   = 2'b01,
		LILC_LB_REMOTE  = 2'b10,
		LILC_LB_PAYLOAD = 2'b11
	} lilc_loopback_e;

	typedef logic [13:0] lilc_addr_t;
	typedef logic [7:0]  lilc_ctrl_t;
endpackage

//--- lilc_line_interface_control.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "lilc_regs.svh"

module lilc_line_interface_control (
	input  wire logic                  clk_sys_i,
	input  wire logic                  arst_n_i,
	input  wire lilc_pkg::lilc_addr_t  avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	input  wire logic [3:0]            avs_byteenable_i,
	output logic [31:0]                avs_readdata_o,
	output logic                       avs_waitrequest_o,
	output logic [1:0]                 avs_response_o,
	input  wire logic                  liu_single_rail_i,
	input  wire logic [1:0]            tx_pcm_i,
	input  wire logic [1:0]            tx_framed_i,
	input  wire logic [1:0]            rx_line_decoded_i,
	input  wire logic [1:0]            rx_slot_i,
	output logic [1:0]                 rx_pcm_o,
	output logic [1:0]                 tx_framer_in_o,
	output logic [1:0]                 tx_encoder_in_o,
	output logic                       rx_framer_bypass_o,
	output logic                       single_rail_o,
	output logic                       force_signal_loss_pattern_o,
	output lilc_pkg::lilc_loopback_e   loopback_select_o
);
	import lilc_pkg::*;

	lilc_ctrl_t     ctrl_reg;
	lilc_ctrl_t     ctrl_next;
	logic           ack_reg;
	logic           ack_next;
	logic [31:0]    rdata_reg;
	logic [31:0]    rdata_next;
	logic [1:0]     resp_reg;
	logic [1:0]     resp_next;
	logic           srail_s1_reg;
	logic           srail_s2_reg;
	logic [1:0]     rx_pcm_reg;
	logic [1:0]     rx_pcm_next;
	logic [1:0]     tx_fr_reg;
	logic [1:0]     tx_fr_next;
	logic [1:0]     tx_enc_reg;
	logic [1:0]     tx_enc_next;
	lilc_loopback_e lb;
	logic           req;
	logic           hit;

	// unit single-rail setting comes from another block's timing
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			srail_s1_reg <= 1'b0;
			srail_s2_reg <= 1'b0;
		end else begin
			srail_s1_reg <= liu_single_rail_i;
			srail_s2_reg <= srail_s1_reg;
		end
	end

	assign req = (avs_read_i || avs_write_i) && !ack_reg;
	assign hit = (avs_address_i == `LILC_LIC_ADDR);
	assign lb  = lilc_loopback_e'(ctrl_reg[`LILC_LB_HI:`LILC_LB_LO]);

	// one wait cycle per access; ack drops waitrequest for one edge
	always_comb begin
		ctrl_next  = ctrl_reg;
		ack_next   = req;
		rdata_next = rdata_reg;
		resp_next  = resp_reg;
		if (req) begin
			resp_next  = hit ? 2'h0 : 2'h2;
			rdata_next = 32'h0000_0000;
			if (avs_read_i && hit) begin
				rdata_next = {24'h00_0000, ctrl_reg};
			end
		end
		// write lands only on the edge that shows waitrequest low,
		// while the master still holds address and data
		if (ack_reg && avs_write_i && hit && avs_byteenable_i[0]) begin
			ctrl_next = avs_writedata_i[7:0];
			// single rail refused while the unit is dual rail
			if (!srail_s2_reg) begin
				ctrl_next[`LILC_SRAIL_BIT] = 1'b0;
			end
		end
		// unit leaving single rail pulls the framer back too
		if (!srail_s2_reg) begin
			ctrl_next[`LILC_SRAIL_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg  <= `LILC_LIC_RESET;
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			resp_reg  <= 2'h0;
		end else begin
			ctrl_reg  <= ctrl_next;
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
			resp_reg  <= resp_next;
		end
	end

	// datapath steering; reserved bits 3:2 are not read here
	always_comb begin
		rx_pcm_next = rx_slot_i;
		tx_fr_next  = tx_pcm_i;
		tx_enc_next = tx_framed_i;
		unique case (lb)
			LILC_LB_NORMAL: begin
				rx_pcm_next = rx_slot_i;
			end
			LILC_LB_LOCAL: begin
				rx_pcm_next = tx_pcm_i;
				tx_enc_next = `LILC_ALL_ONES;
			end
			LILC_LB_REMOTE: begin
				// decoded line data feeds the encoder directly
				tx_enc_next = rx_line_decoded_i;
			end
			LILC_LB_PAYLOAD: begin
				// framer reframes on its own transmit timing
				tx_fr_next = rx_slot_i;
			end
		endcase
		// loss pattern overrides every path toward the line
		if (ctrl_reg[`LILC_FORCE_BIT]) begin
			tx_enc_next = 2'h0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_pcm_reg <= 2'h0;
			tx_fr_reg  <= 2'h0;
			tx_enc_reg <= 2'h0;
		end else begin
			rx_pcm_reg <= rx_pcm_next;
			tx_fr_reg  <= tx_fr_next;
			tx_enc_reg <= tx_enc_next;
		end
	end

	assign avs_waitrequest_o           = !ack_reg;
	assign avs_readdata_o              = rdata_reg;
	assign avs_response_o              = resp_reg;
	assign rx_pcm_o                    = rx_pcm_reg;
	assign tx_framer_in_o              = tx_fr_reg;
	assign tx_encoder_in_o             = tx_enc_reg;
	assign rx_framer_bypass_o          = (lb == LILC_LB_REMOTE);
	assign single_rail_o               = ctrl_reg[`LILC_SRAIL_BIT];
	assign force_signal_loss_pattern_o = ctrl_reg[`LILC_FORCE_BIT];
	assign loopback_select_o           = lb;

	local_loop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_LOCAL && !ctrl_reg[7] && $stable(lb)
		|=> rx_pcm_o == $past(tx_pcm_i) && tx_encoder_in_o == 2'h3)
		else $error("local loopback path wrong");

	force_loss_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		ctrl_reg[7] |=> tx_encoder_in_o == 2'h0)
		else $error("loss pattern not forced");

	srail_gate_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!srail_s2_reg |=> !single_rail_o)
		else $error("single rail set while unit dual");

	normal_path_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_NORMAL && !ctrl_reg[7]
		|=> rx_pcm_o == $past(rx_slot_i)
		&& tx_encoder_in_o == $past(tx_framed_i))
		else $error("normal path wrong");

	remote_loop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_REMOTE && !ctrl_reg[7]
		|=> tx_encoder_in_o == $past(rx_line_decoded_i))
		else $error("remote loopback path wrong");

	payload_loop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_PAYLOAD |=> tx_framer_in_o == $past(rx_slot_i))
		else $error("payload loopback path wrong");

	write_store_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		avs_write_i && !avs_waitrequest_o && hit && avs_byteenable_i[0]
		|-> ##1 ctrl_reg[5:2] == $past(avs_writedata_i[5:2]))
		else $error("write not stored");

	bus_ack_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o)
		else $error("access not answered in one cycle");

	unmapped_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		avs_read_i && avs_waitrequest_o && !hit
		|=> avs_response_o == 2'h2 && avs_readdata_o == 32'h0000_0000)
		else $error("unmapped read answered wrongly");

	// paths each mode must leave alone
	local_frame_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_LOCAL |=> tx_framer_in_o == $past(tx_pcm_i))
		else $error("local loopback framer input wrong");

	remote_rx_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_REMOTE |=> rx_pcm_o == $past(rx_slot_i))
		else $error("remote loopback receive path wrong");

	remote_frame_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_REMOTE |=> tx_framer_in_o == $past(tx_pcm_i))
		else $error("remote loopback framer input wrong");

	payload_enc_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_PAYLOAD && !ctrl_reg[7]
		|=> tx_encoder_in_o == $past(tx_framed_i))
		else $error("payload loopback encoder path wrong");

	payload_rx_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_PAYLOAD |=> rx_pcm_o == $past(rx_slot_i))
		else $error("payload loopback receive path wrong");

	normal_frame_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lb == LILC_LB_NORMAL |=> tx_framer_in_o == $past(tx_pcm_i))
		else $error("normal framer input wrong");

	bypass_mode_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		rx_framer_bypass_o == (loopback_select_o == LILC_LB_REMOTE))
		else $error("bypass not tied to remote loopback");

	// register fields follow the landed write
	force_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		ack_reg && avs_write_i && hit && avs_byteenable_i[0]
		|=> force_signal_loss_pattern_o == $past(avs_writedata_i[7]))
		else $error("force bit not stored");

	srail_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		ack_reg && avs_write_i && hit && avs_byteenable_i[0] && srail_s2_reg
		&& srail_s1_reg |=> single_rail_o == $past(avs_writedata_i[6]))
		else $error("single rail bit not stored");

	lb_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		ack_reg && avs_write_i && hit && avs_byteenable_i[0]
		|=> loopback_select_o == $past(avs_writedata_i[5:4]))
		else $error("loopback select not stored");

	ctrl_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!(ack_reg && avs_write_i) && srail_s2_reg |=> $stable(ctrl_reg))
		else $error("register changed without write");

	read_data_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		avs_read_i && avs_waitrequest_o && hit
		|=> avs_readdata_o == {24'h00_0000, $past(ctrl_reg)}
		&& avs_response_o == 2'h0)
		else $error("mapped read answered wrongly");

	wait_idle_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
		else $error("answer without request");

	ack_once_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for two cycles");

	write_early_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		avs_write_i && avs_waitrequest_o && srail_s2_reg |=> $stable(ctrl_reg))
		else $error("write landed before answer");
endmodule
`default_nettype wire

//--- lilc_line_partner.sv
`timescale 1ns/1ns
`default_nettype none
module lilc_line_partner (
	input  wire logic       clk_sys_i,
	input  wire logic       arst_n_i,
	input  wire logic       single_rail_req_i,
	output logic            liu_single_rail_o,
	output logic [1:0]      rx_line_decoded_o
);
	// steady marks from far end make remote loopback easy to tell
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			liu_single_rail_o <= 1'b0;
			rx_line_decoded_o <= 2'h0;
		end else begin
			liu_single_rail_o <= single_rail_req_i;
			rx_line_decoded_o <= 2'h1;
		end
	end
endmodule
`default_nettype wire

//--- line_interface_loopback_control_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "lilc_regs.svh"
module line_interface_loopback_control_test;
	import lilc_pkg::*;
	logic           clk = 0, rst_n = 0, rd = 0, wr = 0, sr_req = 0;
	logic           liu_sr, byp, srail, frc, wreq;
	lilc_addr_t     adr = 0;
	logic [31:0]    wd = 0, rdo, rdata;
	logic [3:0]     be = 4'h1;
	logic [1:0]     tx_pcm = 2'h1, tx_fr = 2'h2, slot = 2'h2;
	logic [1:0]     line, rsp, rspo, rx_pcm, fr_in, enc;
	lilc_loopback_e lb;
	int             fails = 0, n_compared = 0, cyc = 0;
	lilc_line_interface_control uut (.clk_sys_i(clk), .arst_n_i(rst_n),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdo),
		.avs_waitrequest_o(wreq), .avs_response_o(rspo),
		.liu_single_rail_i(liu_sr), .tx_pcm_i(tx_pcm), .tx_framed_i(tx_fr),
		.rx_line_decoded_i(line), .rx_slot_i(slot), .rx_pcm_o(rx_pcm),
		.tx_framer_in_o(fr_in), .tx_encoder_in_o(enc),
		.rx_framer_bypass_o(byp), .single_rail_o(srail),
		.force_signal_loss_pattern_o(frc), .loopback_select_o(lb));
	lilc_line_partner far (.clk_sys_i(clk), .arst_n_i(rst_n),
		.single_rail_req_i(sr_req), .liu_single_rail_o(liu_sr),
		.rx_line_decoded_o(line));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// old values are seen right after the edge, as all flops use nba
	task automatic acc(input logic w, input lilc_addr_t a, input logic [7:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h0, d};
		do @(posedge clk); while (wreq !== 1'b0);
		rdata = rdo;
		rsp = rspo;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic mode(input logic [1:0] m);
		acc(1, `LILC_LIC_ADDR, {2'h0, m, 4'hC});
		repeat (3) @(posedge clk);
		chk("rx_pcm", rx_pcm, m == 1 ? tx_pcm : slot);
		chk("fr_in", fr_in, m == 3 ? slot : tx_pcm);
		chk("enc", enc, m == 1 ? 2'h3 : m == 2 ? 2'h1 : tx_fr);
		chk("bypass", byp, m == 2);
		chk("lb", lb, m);
	endtask
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			test_done;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		acc(0, `LILC_LIC_ADDR, 8'h00);
		chk("reset", rdata, 32'h0);
		acc(1, `LILC_LIC_ADDR, 8'h4C);
		acc(0, `LILC_LIC_ADDR, 8'h00);
		chk("dual", rdata, 32'hC);
		sr_req <= 1'b1;
		repeat (4) @(posedge clk);
		acc(1, `LILC_LIC_ADDR, 8'h40);
		acc(0, `LILC_LIC_ADDR, 8'h00);
		chk("single", rdata, 32'h40);
		chk("srail", srail, 1'b1);
		sr_req <= 1'b0;
		repeat (5) @(posedge clk);
		chk("srail", srail, 1'b0);
		be <= 4'h0;
		acc(1, `LILC_LIC_ADDR, 8'hFF);
		be <= 4'h1;
		acc(0, `LILC_LIC_ADDR, 8'h00);
		chk("masked", rdata, 32'h0);
		acc(1, 14'h0408, 8'hFF);
		chk("resp", rsp, 2'h2);
		acc(0, 14'h0408, 8'h00);
		chk("resp", rsp, 2'h2);
		acc(0, `LILC_LIC_ADDR, 8'h00);
		chk("resp", rsp, 2'h0);
		chk("nostore", rdata, 32'h0);
		for (int m = 0; m < 4; m++) mode(m[1:0]);
		acc(1, `LILC_LIC_ADDR, 8'hA0);
		repeat (3) @(posedge clk);
		chk("loss", enc, 2'h0);
		chk("force", frc, 1'b1);
		test_done;
	end
endmodule
`default_nettype wire
